// file: logic/asa_alarm_top.sv
// module: alarm status aggregator with register port and status pin
`timescale 1ns/1ps
// Operation
// - The read-only summary bit is 1 when any unmasked flag is set.
// - A select bit routes the summary bit onto the status output pin.
// - Flag 5 sets when any active lane FIFO overflows or underflows.
// - Flag 4 sets whenever the PLL is not locked.
// - In 8b/10b modes flag 3 sets when the link is up but not sending.
// - In 64b/66b modes flag 3 sets at link start and on realignment.
// - Flag 2 sets when a sysref event realigns the internal clocks.
// - Flag 1 sets when oscillators are off, synced or A/B mismatch.
// - Flag 0 sets when the A and B clock dividers do not match.
// - Each flag is sticky, writing 1 clears it and 0 leaves it.
// - After reset all six flags read 1, giving 0x3f.
// - With the link disabled only the divider flag is meaningful.
// - A mask register, all set at reset, hides flags from the summary.
// - Per-lane FIFO flags are kept and all clear with flag 5's clear.
module asa_alarm_top
   import asa_pkg::*;
(
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   // register port
   input  wire logic [11:0]           reg_addr_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   input  wire logic [7:0]            reg_wdata_in,
   output logic      [7:0]            reg_rdata_out,
   // internal health sources
   input  wire logic [ASA_NLANES-1:0] lane_active_in,
   input  wire logic [ASA_NLANES-1:0] lane_fifo_err_in,
   input  wire logic                  pll_locked_in,
   input  wire logic                  link_enable_in,
   input  wire logic                  link_mode_66b_in,
   input  wire logic                  link_data_state_in,
   input  wire logic                  link_realign_in,
   input  wire logic                  sysref_realign_in,
   input  wire logic                  osc_sync_in,
   input  wire logic                  osc_phase_mismatch_in,
   input  wire logic                  div_mismatch_in,
   input  wire logic                  cal_status_in,
   output logic                       status_output_pin_out
);
   import asa_pkg::*;

   // ********************************************************************
   // overview
   // ********************************************************************
   // plain strobe port: a read or write is taken at the rising edge that
   // sees its strobe high, with no wait states
   // read data is registered, so it shows one cycle after the read strobe
   // and drops back to zero in the cycle after that
   // writes act at the edge that takes them; a write-one clear loses to a
   // set condition present in that same cycle, so a lasting fault can
   // never be hidden by software clearing it
   // the summary bit is registered from the flag and mask registers, so it
   // lags a flag change by one cycle; the pin is registered on that edge
   // trade-off: one extra cycle of alarm latency buys a glitch-free pin
   // unmapped addresses read zero and ignore writes; the summary register
   // is read-only, a write to it is dropped
   // with the link disabled only the divider flag is meaningful; the other
   // flags still run, so software must clear them once the link is up

   // ********************************************************************
   // state
   // ********************************************************************
   logic [ASA_NFLAGS-1:0] alarm_flag_mask_q;
   logic [ASA_NFLAGS-1:0] alarm_flag_mask_d;
   logic [ASA_NLANES-1:0] lanes_q;
   logic [ASA_NLANES-1:0] lanes_d;
   logic                  statsel_q;
   logic                  statsel_d;
   logic                  link_en_q;
   logic                  summary_q;
   logic                  summary_d;
   logic                  pin_q;
   logic                  pin_d;
   logic [7:0]            rdata_q;
   logic [7:0]            rdata_d;
   logic [ASA_NLANES-1:0] lane_err;
   logic                  link_start;
   logic [ASA_NFLAGS-1:0] flags;

   asa_flag_if fl ();

   asa_flag_bank u_bank
   (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .fl       (fl.bank)
   );

   assign flags = fl.flags;

   // address match, used by both write and read decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction : hit

   // ********************************************************************
   // flag set conditions
   // ********************************************************************
   // only active lanes report; inactive lanes may run garbage FIFOs
   assign lane_err   = lane_fifo_err_in & lane_active_in;
   assign link_start = link_enable_in & ~link_en_q;

   always_comb
   begin
      fl.set = '0;
      // any active lane overflow or underflow
      fl.set[ASA_BIT_FIFO]    = |lane_err;
      // level: holds the flag for as long as the pll is out of lock
      fl.set[ASA_BIT_PLL]     = ~pll_locked_in;
      // undefined-by-contract while link is off; we just keep logic simple
      // 64b/66b has no data state, so start-up and realign stand in
      if (link_mode_66b_in)
         fl.set[ASA_BIT_LINK] = link_start | link_realign_in;
      else
         fl.set[ASA_BIT_LINK] = link_enable_in & ~link_data_state_in;
      // internal clocks realigned by a sysref event
      fl.set[ASA_BIT_REALIGN] = sysref_realign_in;
      // oscillators off, resynchronised or out of step between channels
      fl.set[ASA_BIT_OSC]     = ~link_enable_in | osc_sync_in
                                | osc_phase_mismatch_in;
      // the one flag that stays meaningful with the link disabled
      fl.set[ASA_BIT_DIV]     = div_mismatch_in;
   end

   // write-one clears of the status register
   always_comb
   begin
      fl.clr = '0;
      if (reg_wr_in && hit(reg_addr_in, ASA_FLAGS_OFS))
         fl.clr = reg_wdata_in[ASA_NFLAGS-1:0];
   end

   // ********************************************************************
   // control registers and per-lane flags
   // ********************************************************************
   // mask and select are plain read/write registers
   // lane bits are write-one-to-clear per byte, and all of them go when
   // the fifo flag is cleared; a lane still in error sets its bit again
   // at once, so software sees a persisting fault
   always_comb
   begin
      alarm_flag_mask_d = alarm_flag_mask_q;
      statsel_d         = statsel_q;
      lanes_d           = lanes_q;
      if (reg_wr_in && hit(reg_addr_in, ASA_MASK_OFS))
         alarm_flag_mask_d = reg_wdata_in[ASA_NFLAGS-1:0];
      if (reg_wr_in && hit(reg_addr_in, ASA_STATSEL_OFS))
         statsel_d = reg_wdata_in[0];
      if (reg_wr_in && hit(reg_addr_in, ASA_LANE_LO_OFS))
         lanes_d[7:0] = lanes_q[7:0] & ~reg_wdata_in;
      if (reg_wr_in && hit(reg_addr_in, ASA_LANE_HI_OFS))
         lanes_d[15:8] = lanes_q[15:8] & ~reg_wdata_in;
      if (fl.clr[ASA_BIT_FIFO])
         lanes_d = '0;
      lanes_d = lanes_d | lane_err;
   end

   // summary, pin mux and read data
   always_comb
   begin
      summary_d = |(flags & ~alarm_flag_mask_q);
      pin_d     = statsel_q ? summary_d : cal_status_in;
      rdata_d   = 8'h00;
      if (reg_rd_in)
      begin
         unique case (1'b1)
            hit(reg_addr_in, ASA_SUMMARY_OFS): rdata_d = {7'h00, summary_q};
            hit(reg_addr_in, ASA_FLAGS_OFS):   rdata_d = {2'h0, flags};
            hit(reg_addr_in, ASA_MASK_OFS):
               rdata_d = {2'h0, alarm_flag_mask_q};
            hit(reg_addr_in, ASA_LANE_LO_OFS): rdata_d = lanes_q[7:0];
            hit(reg_addr_in, ASA_LANE_HI_OFS): rdata_d = lanes_q[15:8];
            hit(reg_addr_in, ASA_STATSEL_OFS): rdata_d = {7'h00, statsel_q};
            default:                           rdata_d = 8'h00;
         endcase
      end
   end

   // one register process for all the top-level state
   // reset values are constants only; the flag bank resets itself
   // link_en_q only feeds the start-up edge detect; it resets low so a
   // link already enabled at reset release counts as a fresh start
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         alarm_flag_mask_q <= ASA_MASK_RST;
         lanes_q           <= ASA_LANE_RST;
         statsel_q         <= ASA_STATSEL_RST;
         link_en_q         <= 1'b0;
         summary_q         <= 1'b0;
         pin_q             <= 1'b0;
         rdata_q           <= 8'h00;
      end
      else
      begin
         alarm_flag_mask_q <= alarm_flag_mask_d;
         lanes_q           <= lanes_d;
         statsel_q         <= statsel_d;
         link_en_q         <= link_enable_in;
         summary_q         <= summary_d;
         pin_q             <= pin_d;
         rdata_q           <= rdata_d;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   // both outputs come straight from flip-flops, so no decode glitch
   // ever reaches the pin
   assign reg_rdata_out         = rdata_q;
   assign status_output_pin_out = pin_q;
endmodule : asa_alarm_top

// file: logic/asa_pkg.sv
// package: register map, field positions and reset values of the alarm block
package asa_pkg;
   // ********************************************************************
   // register map
   // ********************************************************************
   localparam logic [11:0] ASA_SUMMARY_OFS  = 12'h2c0;
   localparam logic [11:0] ASA_FLAGS_OFS    = 12'h2c1;
   localparam logic [11:0] ASA_MASK_OFS     = 12'h2c2;
   localparam logic [11:0] ASA_LANE_LO_OFS  = 12'h2c4;
   localparam logic [11:0] ASA_LANE_HI_OFS  = 12'h2c5;
   localparam logic [11:0] ASA_STATSEL_OFS  = 12'h2c6;
   // ********************************************************************
   // fields and resets
   // ********************************************************************
   localparam int          ASA_NFLAGS       = 6;
   localparam int          ASA_NLANES       = 16;
   localparam int          ASA_BIT_FIFO     = 5;
   localparam int          ASA_BIT_PLL      = 4;
   localparam int          ASA_BIT_LINK     = 3;
   localparam int          ASA_BIT_REALIGN  = 2;
   localparam int          ASA_BIT_OSC      = 1;
   localparam int          ASA_BIT_DIV      = 0;
   localparam logic [5:0]  ASA_FLAGS_RST    = 6'h3f;
   localparam logic [5:0]  ASA_MASK_RST     = 6'h3f;
   localparam logic [15:0] ASA_LANE_RST     = 16'hffff;
   localparam logic        ASA_STATSEL_RST  = 1'h0;
endpackage : asa_pkg

// file: logic/asa_flag_if.sv
// interface: per-flag set and clear strobes between top and flag bank
`timescale 1ns/1ps
interface asa_flag_if;
   logic [5:0] set;
   logic [5:0] clr;
   logic [5:0] flags;
   modport ctrl (output set, output clr, input flags);
   modport bank (input set, input clr, output flags);
endinterface : asa_flag_if

// file: logic/asa_flag_bank.sv
// module: bank of sticky write-one-to-clear alarm flags
`timescale 1ns/1ps
module asa_flag_bank
   import asa_pkg::*;
(
   input  wire logic   clk_in,
   input  wire logic   reset_in,
   asa_flag_if.bank    fl
);
   logic [ASA_NFLAGS-1:0] flags_q;
   logic [ASA_NFLAGS-1:0] flags_d;

   // set beats clear so an event in the clear cycle is kept
   always_comb
   begin
      for (int i = 0; i < ASA_NFLAGS; i++)
      begin
         flags_d[i] = fl.set[i] | (flags_q[i] & ~fl.clr[i]);
      end
   end

   // all flags come up set after reset
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         flags_q <= ASA_FLAGS_RST;
      else
         flags_q <= flags_d;
   end

   assign fl.flags = flags_q;
endmodule : asa_flag_bank

// file: verif/asa_chk_checker.sv
// checker: port-level assertions for the alarm block
`timescale 1ns/1ps
module asa_chk
   import asa_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        pll_locked_in,
   input wire logic        sysref_realign_in,
   input wire logic        osc_phase_mismatch_in,
   input wire logic        div_mismatch_in,
   input wire logic        status_output_pin_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   // read and write decodes of the flag and summary registers
   logic rf, rs, wc;
   assign rf = reg_rd_in && reg_addr_in == ASA_FLAGS_OFS;
   assign rs = reg_rd_in && reg_addr_in == ASA_SUMMARY_OFS;
   assign wc = reg_wr_in && reg_addr_in == ASA_FLAGS_OFS;
   AST_PLL: assert property (!pll_locked_in ##1 rf
      |=> reg_rdata_out[4]) else $error("pll flag not set");
   AST_SYS: assert property (sysref_realign_in ##1 rf
      |=> reg_rdata_out[2]) else $error("realign flag not set");
   AST_OSC: assert property (osc_phase_mismatch_in ##1 rf
      |=> reg_rdata_out[1]) else $error("phase flag not set");
   AST_DIV: assert property (div_mismatch_in ##1 rf
      |=> reg_rdata_out[0]) else $error("divider flag not set");
   AST_SUM: assert property (rs
      |=> reg_rdata_out[7:1] == 7'h00) else $error("summary upper bits set");
   AST_RSV: assert property (rf
      |=> reg_rdata_out[7:6] == 2'h0) else $error("flag upper bits set");
   AST_WIN: assert property (wc && !pll_locked_in ##1 !wc ##1 rf
      |=> reg_rdata_out[4]) else $error("clear beat a set");
   AST_CLR: assert property (wc && reg_wdata_in[4] && pll_locked_in ##1
      pll_locked_in ##1 rf |=> !reg_rdata_out[4]) else $error("flag not cleared");
   cover property (rs ##1 reg_rdata_out[0]);
   cover property (rf);
   cover property (wc);
   cover property (status_output_pin_out);
endmodule : asa_chk
bind asa_alarm_top asa_chk i_chk (.clk_in, .reset_in, .reg_addr_in,
   .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .pll_locked_in,
   .sysref_realign_in, .osc_phase_mismatch_in, .div_mismatch_in,
   .status_output_pin_out);

// file: verif/asa_host.sv
// partner: host processor issuing register reads and writes
`timescale 1ns/1ps
module asa_host
(
   input  wire logic        clk_in,
   output logic      [11:0] addr_out = 12'h000,
   output logic             wr_out = 1'b0,
   output logic             rd_out = 1'b0,
   output logic      [7:0]  wdata_out = 8'h00,
   input  wire logic [7:0]  rdata_in
);
   // one cycle request; released lines invert so stale values never match
   task automatic acc(input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = w;
      rd_out = !w;
      @(negedge clk_in);
      q = rdata_in;
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : acc
endmodule : asa_host

// file: verif/test_alarm_status_aggregator.sv
// testbench: flags, mask, summary, lane bits and status pin
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module test_alarm_status_aggregator;
   import asa_pkg::*;
   logic        clk_in = 0, reset_in = 1, pll = 1, len = 1, cal = 0;
   logic        dst = 1, srl = 0, opm = 0, dvm = 0, osy = 0, wr, rd, pin;
   logic [15:0] err = 0;
   logic [15:0] act = 16'hffff;
   logic        m66 = 0, lre = 0;
   logic [11:0] addr;
   logic [7:0]  wd, rdat, q;
   int          fails = 0, tests_run = 0, ln, i;
   asa_alarm_top i_dut (.clk_in, .reset_in, .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
      .lane_active_in(act), .lane_fifo_err_in(err), .pll_locked_in(pll),
      .link_enable_in(len), .link_mode_66b_in(m66), .link_data_state_in(dst),
      .link_realign_in(lre), .sysref_realign_in(srl), .osc_sync_in(osy),
      .osc_phase_mismatch_in(opm), .div_mismatch_in(dvm), .cal_status_in(cal),
      .status_output_pin_out(pin));
   asa_host h (.clk_in, .addr_out(addr), .wr_out(wr), .rd_out(rd),
      .wdata_out(wd), .rdata_in(rdat));
   function automatic logic [7:0] exp_flag(input int b);
      return 8'h01 << b;
   endfunction : exp_flag
   // one health cause at a time, all others quiet
   task automatic cause(input int b, input logic v);
      pll = !(v && b == 4);
      dst = !(v && b == 3);
      srl = v && b == 2;
      opm = v && b == 1;
      dvm = v && b == 0;
      err = (v && b == 5) ? 16'h0001 << ln : 16'h0000;
   endtask : cause
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   initial
      forever #5 clk_in = ~clk_in;
   // watchdog: the whole run needs well under 2000 cycles
   initial
   begin
      #20000;
      fails++;
      stop_test();
   end
   initial
   begin
      void'($urandom(32'h9f0c));
      repeat (2) @(posedge clk_in);
      @(negedge clk_in) reset_in = 0;
      h.acc(0, ASA_FLAGS_OFS, 0, q);
      `CHK("flags", 8'h3f, q)
      h.acc(0, ASA_MASK_OFS, 0, q);
      `CHK("mask", 8'h3f, q)
      h.acc(1, ASA_SUMMARY_OFS, 8'hff, q);
      h.acc(0, ASA_SUMMARY_OFS, 0, q);
      `CHK("summary", 8'h00, q)
      h.acc(1, ASA_FLAGS_OFS, 8'h3f, q);
      h.acc(0, ASA_LANE_HI_OFS, 0, q);
      `CHK("lanes", 8'h00, q)
      h.acc(1, ASA_STATSEL_OFS, 8'h01, q);
      for (i = 0; i < 6; i++)
      begin
         ln = $urandom % 16;
         @(negedge clk_in);
         cause(i, 1);
         h.acc(0, ASA_FLAGS_OFS, 0, q);
         `CHK("flag", exp_flag(i), q)
         h.acc(1, ASA_FLAGS_OFS, 8'h3f, q);
         cause(i, 0);
         h.acc(0, ASA_FLAGS_OFS, 0, q);
         `CHK("set wins", exp_flag(i), q)
         h.acc(1, ASA_MASK_OFS, 8'h3f ^ exp_flag(i), q);
         h.acc(0, ASA_SUMMARY_OFS, 0, q);
         `CHK("summary", 8'h01, q)
         `CHK("pin", 1'b1, pin)
         h.acc(0, ln < 8 ? ASA_LANE_LO_OFS : ASA_LANE_HI_OFS, 0, q);
         `CHK("lane", i == 5 ? 8'h01 << (ln % 8) : 8'h00, q)
         h.acc(1, ASA_FLAGS_OFS, exp_flag(i), q);
         h.acc(0, ASA_FLAGS_OFS, 0, q);
         `CHK("cleared", 8'h00, q)
         h.acc(1, ASA_MASK_OFS, 8'h3f, q);
      end
      // 64b/66b: link start, then realign with sync and an idle lane error
      m66 = 1;
      len = 0;
      h.acc(1, ASA_FLAGS_OFS, 8'h3f, q);
      len = 1;
      h.acc(1, ASA_FLAGS_OFS, 8'h37, q);
      h.acc(0, ASA_FLAGS_OFS, 0, q);
      `CHK("start", 8'h08, q)
      h.acc(1, ASA_FLAGS_OFS, 8'h08, q);
      lre = 1;
      osy = 1;
      ln = $urandom % 16;
      err = 16'h0001 << ln;
      act = ~err;
      h.acc(0, ASA_FLAGS_OFS, 0, q);
      `CHK("realign", 8'h0a, q)
      lre = 0;
      osy = 0;
      err = 16'h0000;
      act = 16'hffff;
      h.acc(0, ln < 8 ? ASA_LANE_LO_OFS : ASA_LANE_HI_OFS, 0, q);
      `CHK("idle lane", 8'h00, q)
      m66 = 0;
      h.acc(1, ASA_STATSEL_OFS, 8'h00, q);
      cal = 1'($urandom);
      @(negedge clk_in);
      `CHK("pin", cal, pin)
      stop_test();
   end
endmodule : test_alarm_status_aggregator
